// File: logic/adapter_address_decode_consts.vh
// Constants for the adapter address decode block
`ifndef ADAPTER_ADDRESS_DECODE_CONSTS_VH
`define ADAPTER_ADDRESS_DECODE_CONSTS_VH

// ---------------------------------------------------------------
// Address constants
// ---------------------------------------------------------------
`define ROM_REGION_BASE      32'h000c0000
`define ROM_STEP_SHIFT       13
`define ROM_WINDOW_SIZE      32'h00002000
`define COPRO_OFFSET         32'h00001000
`define COPRO_STEP_SHIFT     7
`define COPRO_BLOCK_SIZE     32'h00000080
`define IO_BLOCK_BASE        16'h2100
`define IO_BLOCK_MASK        16'hfff0
`define IO_INST_SHIFT        4
`define IO_BLOCK_SIZE        16'h0010
`define VMEM_REGION_SHIFT    25
`define VMEM_INST_SHIFT      22
`define VMEM_SLICE_SIZE      32'h00400000
`define AP1M_STEP_SHIFT      20
`define AP1M_SIZE            32'h00100000

// ---------------------------------------------------------------
// Setup port
// ---------------------------------------------------------------
`define SETUP_PORT           16'h0094
`define SETUP_ENTER_VAL      8'hdf
`define SETUP_LEAVE_VAL      8'hff

// ---------------------------------------------------------------
// Indexed and mode registers
// ---------------------------------------------------------------
`define MONITOR_INDEX        8'h52
`define OPMODE_OFFSET        4'h0
`define INDEX_OFFSET         4'ha
`define DATA_OFFSET          4'hb
`define OPMODE_LEGACY_BIT    0
`define OPMODE_TEXT132_BIT   2
`define IDENT_LO_PORT        16'h0100
`define IDENT_HI_PORT        16'h0101
// Arbitrary value, not a real assigned code
`define IDENT_CODE_DEFAULT   16'h5a30

`endif

// File: logic/window_match.v
// Base-and-size window comparator
`timescale 1ns/10ps
`default_nettype none

module window_match (
    input  wire [31:0] addr,
    input  wire [31:0] base,
    input  wire [31:0] size,
    input  wire        enable,
    output wire        hit
);
    wire [32:0] top = {1'b0, base} + {1'b0, size};

    // Full 32-bit compare, end exclusive
    assign hit = enable && (addr >= base) && ({1'b0, addr} < top);
endmodule // window_match

`default_nettype wire

// File: logic/adapter_address_decode.v
// Configuration-driven address decode of a graphics adapter
`timescale 1ns/10ps
`default_nettype none
`include "adapter_address_decode_consts.vh"

// Overview of operation
// - ROM base = field times 2000h plus C0000h
// - Instance number from config 2 bits 1-3
// - Coprocessor block at ROM+1000h+128*instance
// - I/O block decoded at 21x0h
// - Base field picks 32MB, instance 4MB
// - 4MB aperture answers only when enabled
// - Bitmap inside video range is local
// - Bitmap outside video range uses mastership
// - Video base compared at full 32 bits
// - 1MB aperture base = field times 100000h
// - Zero 1MB field disables that aperture
// - Port 94h DF enters, FF leaves setup
// - Identification code readable in setup mode
// - Monitor type read at index 52h
// - Mode bits 0 and 2 show state
// - Mode register at I/O block offset 0

module adapter_address_decode (
    input  wire        core_clk,
    input  wire        reset,
    input  wire [7:0]  cfg_reg2,
    input  wire [7:0]  cfg_reg4,
    input  wire [7:0]  cfg_reg5,
    input  wire [15:0] io_addr,
    input  wire [7:0]  io_wdata,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire [31:0] mem_addr,
    input  wire        mem_req,
    input  wire [31:0] bitmap_addr,
    input  wire        bitmap_req,
    input  wire [7:0]  reg_index,
    input  wire [3:0]  monitor_type_code,
    input  wire        legacy_mode_en,
    input  wire        text132_mode_en,
    output reg         setup_mode_q,
    output reg  [7:0]  io_rdata_q,
    output reg         io_hit_q,
    output reg         rom_hit_q,
    output reg         copro_hit_q,
    output reg         ap4m_hit_q,
    output reg         ap1m_hit_q,
    output reg         bitmap_local_q,
    output reg         bitmap_master_q,
    output reg  [31:0] rom_base_q,
    output reg  [31:0] vmem_base_q
);
    parameter [15:0] ADAPTER_IDENT_CODE = `IDENT_CODE_DEFAULT; // Arbitrary

    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    // Zero-extends a field and moves it up to bit position pos
    function [31:0] place_field;
        input [6:0]   field;
        input integer pos;
        begin
            place_field = {25'h0000000, field} << pos;
        end
    endfunction

    // True when an I/O address lands on one register of a block
    function io_reg_at;
        input [15:0] addr;
        input [15:0] base;
        input [3:0]  offset;
        begin
            io_reg_at = ((addr & `IO_BLOCK_MASK) == base) &&
                (addr[3:0] == offset);
        end
    endfunction

    // -----------------------------------------------------------
    // Configuration fields
    // -----------------------------------------------------------
    // Reserved configuration bits are never looked at
    wire [3:0] rom_field  = cfg_reg2[7:4];
    wire [2:0] inst_num   = cfg_reg2[3:1];
    wire [6:0] vmem_field = cfg_reg4[7:1];
    wire       ap4m_en    = cfg_reg4[0];
    wire [3:0] ap1m_field = cfg_reg5[3:0];

    // -----------------------------------------------------------
    // Decoded bases, purely combinational so writes apply at once
    // -----------------------------------------------------------
    wire [31:0] rom_base = `ROM_REGION_BASE +
        place_field({3'h0, rom_field}, `ROM_STEP_SHIFT);
    wire [31:0] copro_base = rom_base + `COPRO_OFFSET +
        place_field({4'h0, inst_num}, `COPRO_STEP_SHIFT);
    wire [15:0] io_base = `IO_BLOCK_BASE |
        ({13'h0000, inst_num} << `IO_INST_SHIFT);
    wire [31:0] vmem_base =
        place_field(vmem_field, `VMEM_REGION_SHIFT) |
        place_field({4'h0, inst_num}, `VMEM_INST_SHIFT);
    wire [31:0] ap1m_base =
        place_field({3'h0, ap1m_field}, `AP1M_STEP_SHIFT);

    // -----------------------------------------------------------
    // Window compares
    // -----------------------------------------------------------
    wire rom_hit;
    wire copro_hit;
    wire ap4m_hit;
    wire ap1m_hit;
    wire vmem_in;

    window_match u_rom (
        .addr   (mem_addr),
        .base   (rom_base),
        .size   (`ROM_WINDOW_SIZE),
        .enable (mem_req),
        .hit    (rom_hit)
    );
    window_match u_copro (
        .addr   (mem_addr),
        .base   (copro_base),
        .size   (`COPRO_BLOCK_SIZE),
        .enable (mem_req),
        .hit    (copro_hit)
    );
    window_match u_ap4m (
        .addr   (mem_addr),
        .base   (vmem_base),
        .size   (`VMEM_SLICE_SIZE),
        .enable (mem_req && ap4m_en),
        .hit    (ap4m_hit)
    );
    window_match u_ap1m (
        .addr   (mem_addr),
        .base   (ap1m_base),
        .size   (`AP1M_SIZE),
        .enable (mem_req && (ap1m_field != 4'h0)),
        .hit    (ap1m_hit)
    );
    // Coprocessor view ignores the aperture enable
    window_match u_vmem (
        .addr   (bitmap_addr),
        .base   (vmem_base),
        .size   (`VMEM_SLICE_SIZE),
        .enable (1'b1),
        .hit    (vmem_in)
    );

    // -----------------------------------------------------------
    // I/O decode
    // -----------------------------------------------------------
    wire io_block   = (io_addr & `IO_BLOCK_MASK) == io_base;
    wire setup_port = io_addr == `SETUP_PORT;

    // Index register picks what the data port returns
    reg [7:0] index_q;
    reg [7:0] rdata_d;

    always @* begin
        rdata_d = 8'h00;
        if (io_reg_at(io_addr, io_base, `OPMODE_OFFSET)) begin
            rdata_d[`OPMODE_LEGACY_BIT]  = legacy_mode_en;
            rdata_d[`OPMODE_TEXT132_BIT] = text132_mode_en;
        end else if (io_reg_at(io_addr, io_base, `INDEX_OFFSET)) begin
            rdata_d = index_q;
        end else if (io_reg_at(io_addr, io_base, `DATA_OFFSET)) begin
            if (index_q == `MONITOR_INDEX)
                rdata_d = {4'h0, monitor_type_code};
        end else if (setup_mode_q && io_addr == `IDENT_LO_PORT) begin
            // Identification answers only while in setup mode
            rdata_d = ADAPTER_IDENT_CODE[7:0];
        end else if (setup_mode_q && io_addr == `IDENT_HI_PORT) begin
            rdata_d = ADAPTER_IDENT_CODE[15:8];
        end
    end

    // -----------------------------------------------------------
    // Setup mode and index state
    // -----------------------------------------------------------
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            setup_mode_q <= 1'b0;
            index_q      <= 8'h00;
        end else begin
            // Any other value on the setup port is ignored
            if (io_wr && setup_port) begin
                if (io_wdata == `SETUP_ENTER_VAL)
                    setup_mode_q <= 1'b1;
                else if (io_wdata == `SETUP_LEAVE_VAL)
                    setup_mode_q <= 1'b0;
            end
            if (io_wr && io_reg_at(io_addr, io_base, `INDEX_OFFSET))
                index_q <= io_wdata;
        end
    end

    // -----------------------------------------------------------
    // Registered outputs
    // -----------------------------------------------------------
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            io_rdata_q      <= 8'h00;
            io_hit_q        <= 1'b0;
            rom_hit_q       <= 1'b0;
            copro_hit_q     <= 1'b0;
            ap4m_hit_q      <= 1'b0;
            ap1m_hit_q      <= 1'b0;
            bitmap_local_q  <= 1'b0;
            bitmap_master_q <= 1'b0;
            rom_base_q      <= 32'h00000000;
            vmem_base_q     <= 32'h00000000;
        end else begin
            // Zero outside a read keeps the returned byte clean
            io_rdata_q      <= io_rd ? rdata_d : 8'h00;
            io_hit_q        <= (io_rd || io_wr) && io_block;
            rom_hit_q       <= rom_hit;
            copro_hit_q     <= copro_hit;
            ap4m_hit_q      <= ap4m_hit;
            ap1m_hit_q      <= ap1m_hit;
            bitmap_local_q  <= bitmap_req && vmem_in;
            bitmap_master_q <= bitmap_req && !vmem_in;
            // Bases are copied out; the decode itself stays combinational
            rom_base_q      <= rom_base;
            vmem_base_q     <= vmem_base;
        end
    end
endmodule // adapter_address_decode

`default_nettype wire

// File: dv/adapter_address_decode_props.sv
// Assertion checker for the address decode
`timescale 1ns/10ps
`default_nettype none
module adapter_address_decode_props (
    input wire logic        core_clk, reset, io_wr, mem_req, bitmap_req,
    input wire logic [7:0]  cfg_reg2, cfg_reg4, cfg_reg5, io_wdata,
    input wire logic [15:0] io_addr,
    input wire logic [31:0] mem_addr, bitmap_addr, rom_base_q, vmem_base_q,
    input wire logic        setup_mode_q, copro_hit_q, ap4m_hit_q,
    input wire logic        ap1m_hit_q, bitmap_local_q, bitmap_master_q
);
    logic [1:0] ok_q;
    wire [31:0] rb = 32'hc0000 + {cfg_reg2[7:4], 13'h0};
    wire [31:0] cb = rb + 32'h1000 + {cfg_reg2[3:1], 7'h0};
    wire [9:0]  vs = {cfg_reg4[7:1], cfg_reg2[3:1]};
    wire        pk = io_wr && io_addr == 16'h0094;
    wire        lo = bitmap_req && bitmap_addr[31:22] == vs;
    wire        hc = mem_req && mem_addr - cb < 32'h80;
    wire        h4 = mem_req && cfg_reg4[0] && mem_addr[31:22] == vs;
    wire        h1 = mem_req && |cfg_reg5[3:0] && mem_addr[31:24] == 8'h0
                     && mem_addr[23:20] == cfg_reg5[3:0];
    // Outputs stay zero one edge past reset
    always_ff @(posedge core_clk or posedge reset)
        if (reset) ok_q <= 2'h0;
        else ok_q <= {ok_q[0], 1'b1};
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_rom_base: assert property (
        ok_q[1] |-> rom_base_q == $past(rb)) else $error("rom base");
    a_vmem_base: assert property (
        ok_q[1] |-> vmem_base_q == {$past(vs), 22'h0})
        else $error("vmem base");
    a_copro_hit: assert property (
        ok_q[1] |-> copro_hit_q == $past(hc)) else $error("copro hit");
    a_big_aperture: assert property (
        ok_q[1] |-> ap4m_hit_q == $past(h4)) else $error("4m hit");
    a_small_aperture: assert property (
        ok_q[1] |-> ap1m_hit_q == $past(h1)) else $error("1m hit");
    a_bitmap_local: assert property (
        ok_q[0] && lo |=> bitmap_local_q && !bitmap_master_q)
        else $error("local");
    a_bitmap_master: assert property (
        ok_q[0] && bitmap_req && !lo |=> bitmap_master_q) else $error("master");
    a_setup_enter: assert property (
        ok_q[0] && pk && io_wdata == 8'hdf |=> setup_mode_q)
        else $error("setup");
    a_setup_hold: assert property (
        !$stable(setup_mode_q) |-> $past(pk)) else $error("setup change");
    cover property (copro_hit_q);
    cover property (ap1m_hit_q);
    cover property ($fell(setup_mode_q));
endmodule // adapter_address_decode_props
`default_nettype wire

// File: dv/host_model.sv
// Host processor model issuing I/O cycles
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] io_rdata_q,
    output var logic [15:0] io_addr,
    output var logic [7:0]  io_wdata,
    output var logic        io_wr,
    output var logic        io_rd
);
    // No interrupt source here, so setup runs masked
    initial {io_addr, io_wdata, io_wr, io_rd} = 26'h0;
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= w;
        io_rd <= !w;
        @(posedge core_clk);
        // Released bus must not keep showing the old address
        io_addr <= ~a;
        io_wdata <= ~d;
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1 q = io_rdata_q;
    endtask
endmodule // host_model
`default_nettype wire

// File: dv/adapter_address_decode_bench.sv
// Self-checking bench for the address decode
`timescale 1ns/10ps
`default_nettype none
module adapter_address_decode_bench;
    localparam logic [15:0] ID = 16'h3c69; // Arbitrary value
    localparam logic [31:0] MK [4] = '{32'h3fff, 32'hff, 32'h7fffff, 32'h1fffff};
    localparam logic [40:0] OP [6] = '{{1'b1, 16'h0094, 8'hdf, 16'h0100},
        {1'b0, 16'h0100, 8'h0, 8'h1, ID[7:0]}, {1'b0, 16'h0101, 8'h0, 8'h1, ID[15:8]},
        {1'b1, 16'h0094, 8'h5a, 16'h0100}, {1'b1, 16'h0094, 8'hff, 16'h0},
        {1'b0, 16'h0100, 8'h0, 16'h0}};
    logic core_clk, reset, mem_req, bitmap_req, legacy_mode_en, text132_mode_en;
    logic [7:0] cfg_reg2, cfg_reg4, cfg_reg5, reg_index, q;
    logic [3:0] monitor_type_code, e;
    logic [1:0] g;
    logic [31:0] mem_addr, bitmap_addr, r, s, rb, vb, a, b, bs [4];
    logic [15:0] io;
    int miscompares = 0, check_count = 0;
    wire [15:0] io_addr;
    wire [7:0] io_wdata, io_rdata_q;
    wire [31:0] rom_base_q, vmem_base_q;
    wire io_wr, io_rd, setup_mode_q, io_hit_q, rom_hit_q, copro_hit_q;
    wire ap4m_hit_q, ap1m_hit_q, bitmap_local_q, bitmap_master_q;
    adapter_address_decode #(.ADAPTER_IDENT_CODE(ID)) adapter_address_decode_i (.*);
    host_model host_model_i (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        miscompares++;
        results();
    end
    initial begin
        reset = 1'b1;
        {mem_req, bitmap_req, legacy_mode_en, text132_mode_en} = 4'h0;
        {cfg_reg2, cfg_reg4, cfg_reg5, reg_index, monitor_type_code} = 36'h0;
        {mem_addr, bitmap_addr} = 64'h0;
        r = $urandom(32'ha1e5);
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        repeat (400) begin
            r = $urandom;
            s = $urandom;
            rb = 32'hc0000 + r[7:4] * 32'h2000;
            vb = {r[15:9], r[3:1], 22'h0};
            bs = '{rb, rb + 32'h1000 + r[3:1] * 32'h80, vb, {r[19:16], 20'h0}};
            a = bs[r[25:24]] + (s & MK[r[25:24]]);
            b = r[31] ? vb + s[22:0] : s;
            e[3] = r[29] && a - rb < 32'h2000;
            e[2] = r[29] && a - bs[1] < 32'h80;
            e[1] = r[29] && r[8] && a[31:22] == vb[31:22];
            e[0] = r[29] && bs[3] != 0 && a[31:20] == bs[3][31:20];
            g = {2{r[28]}} & {b[31:22] == vb[31:22], b[31:22] != vb[31:22]};
            @(posedge core_clk);
            {cfg_reg5, cfg_reg4, cfg_reg2} <= r[23:0];
            {mem_req, bitmap_req, legacy_mode_en, text132_mode_en} <= r[29:26];
            {mem_addr, bitmap_addr, monitor_type_code, reg_index} <= {a, b, s[11:0]};
            @(posedge core_clk);
            #1;
            check(rom_base_q, rb);
            check(vmem_base_q, vb);
            check({rom_hit_q, copro_hit_q, ap4m_hit_q, ap1m_hit_q}, e);
            check({bitmap_local_q, bitmap_master_q}, g);
        end
        io = {8'h21, 1'b0, cfg_reg2[3:1], 4'h0};
        for (int i = 0; i < 6; i++) begin
            host_model_i.xfer(OP[i][40], OP[i][39:24], OP[i][23:16], q);
            check({setup_mode_q, q}, OP[i][8:0]);
        end
        for (int m = 0; m < 4; m++) begin
            {text132_mode_en, legacy_mode_en} <= m[1:0];
            host_model_i.xfer(1'b0, io, 8'h0, q);
            check({io_hit_q, q}, {6'h20, m[1], 1'b0, m[0]});
        end
        host_model_i.xfer(1'b1, io + 16'ha, 8'h52, q);
        host_model_i.xfer(1'b0, io + 16'hb, 8'h0, q);
        check(q, {4'h0, monitor_type_code});
        results();
    end
endmodule // adapter_address_decode_bench
bind adapter_address_decode adapter_address_decode_props
    adapter_address_decode_props_i (.*);
`default_nettype wire
